// file: wrp_pkg.sv
// constants shared by the working-register pointer block
package wrp_pkg;
    localparam logic [7:0] WRP_FIRST_PTR_ADDR  = 8'hD6; // first slice pointer location
    localparam logic [7:0] WRP_SECOND_PTR_ADDR = 8'hD7; // second slice pointer location
    localparam logic [7:0] WRP_FIRST_PTR_RST   = 8'hC0; // reset: slice C0-C7
    localparam logic [7:0] WRP_SECOND_PTR_RST  = 8'hC8; // reset: slice C8-CF
    localparam logic [7:0] WRP_PAIR_STEP       = 8'h08; // second pointer offset on combined set
    localparam logic [3:0] WRP_WORK_NIBBLE     = 4'hC;  // 8-bit operand escape to working regs
    localparam logic [1:0] WRP_SET2_TOP        = 2'h3;  // addr[7:6] of the C0-FF range

    // pointer update commands from the decoder
    typedef enum logic [3:0] {
        WRP_CMD_NONE   = 4'b0001, // no pointer instruction
        WRP_CMD_BOTH   = 4'b0010, // combined set: first=imm, second=imm+8
        WRP_CMD_FIRST  = 4'b0100, // set first pointer only
        WRP_CMD_SECOND = 4'b1000  // set second pointer only
    } wrp_cmd_type;
endpackage

// file: wrp_addr_expand.sv
// expands a working-register operand to a full register-file address
`timescale 1ns/1ps
`default_nettype none
module wrp_addr_expand
    import wrp_pkg::*;
(
    input  wire logic [7:0] first_ptr,   // first slice pointer value
    input  wire logic [7:0] second_ptr,  // second slice pointer value
    input  wire logic [3:0] operand,     // 4-bit working operand
    output logic      [7:0] full_addr    // resolved register address
);
    // pointer choice by operand bit 3, low pointer bits dropped
    always_comb begin
        if (operand[3]) begin
            full_addr = {second_ptr[7:3], operand[2:0]};
        end else begin
            full_addr = {first_ptr[7:3], operand[2:0]};
        end
    end
endmodule
`default_nettype wire

// file: wrp_core.sv
// working-register slice pointers and operand address formation
//
// Behaviour
// - pointers live at D6H and D7H
// - reset selects C0-C7 and C8-CF
// - pointers load by set, load or clear
// - combined set: second gets operand plus eight
// - single set touches only its pointer
// - working operands reach only selected slices
// - working accesses never land in set 2
// - direct addressing reaches all but set 2
// - pair: even address holds high byte
// - common block reachable on any page
// - operand bit 3 picks the pointer
// - address is pointer[7:3] with operand[2:0]
// - low bits pick one of eight registers
// - operand nibble 1100B means working register
`timescale 1ns/1ps
`default_nettype none
module wrp_core
    import wrp_pkg::*;
(
    input  wire logic        clk_sys,        // cpu clock
    input  wire logic        rst_b,          // synchronous reset, active low
    input  wire logic        clk_en,         // freezes all state when low
    input  wire logic        instr_end,      // last cycle of current instruction
    input  wire wrp_cmd_type ptr_cmd,        // pointer set instruction kind
    input  wire logic [7:0]  ptr_imm,        // immediate for pointer set
    input  wire logic        reg_wr,         // register write (load/clear)
    input  wire logic [7:0]  reg_wr_addr,    // physical address written
    input  wire logic [7:0]  reg_wr_data,    // data written
    input  wire logic [7:0]  reg_rd_addr,    // physical address read
    output logic      [7:0]  reg_rd_data,    // pointer read data
    output logic             reg_rd_hit,     // read address is a pointer
    input  wire logic        op_is_work,     // operand is a 4-bit working operand
    input  wire logic [7:0]  op_addr,        // 4-bit in low nibble, or 8-bit address
    input  wire logic        op_pair,        // operand names a 16-bit pair
    input  wire logic        op_set1,        // 8-bit C0-FF operand aims at set 1
    output logic      [7:0]  eff_addr,       // resolved register-file address
    output logic      [7:0]  eff_addr_lo,    // low byte address of a pair
    output logic             eff_working,    // resolved through a pointer
    output logic             eff_set2_block, // access would hit set 2
    output logic      [7:0]  first_slice_pointer,  // live first pointer
    output logic      [7:0]  second_slice_pointer  // live second pointer
);
    logic [7:0] first_r;       // committed first pointer
    logic [7:0] first_nxt;
    logic [7:0] second_r;      // committed second pointer
    logic [7:0] second_nxt;
    logic [7:0] first_pend_r;  // value written during current instruction
    logic [7:0] first_pend_nxt;
    logic [7:0] second_pend_r;
    logic [7:0] second_pend_nxt;
    logic [3:0] work_nib;      // nibble fed to the expander
    logic [7:0] work_addr;     // expanded working address
    logic       is_work;       // operand resolves through a pointer
    logic [1:0] wr_sel;        // write address hits a pointer
    logic [1:0] rd_sel;        // read address hits a pointer

    // one-hot pointer hit: bit 0 first, bit 1 second; shared by the
    // write and read decoders so the two maps cannot drift apart
    function automatic logic [1:0] ptr_hit(input logic [7:0] a);
        logic [1:0] h;
        h = 2'h0;
        if (a == WRP_FIRST_PTR_ADDR) begin
            h = 2'h1;
        end else if (a == WRP_SECOND_PTR_ADDR) begin
            h = 2'h2;
        end
        return h;
    endfunction

    // pending copies absorb writes; committed copies change only at
    // instruction end so address formation never shifts mid-instruction
    always_comb begin
        first_pend_nxt  = first_pend_r;
        second_pend_nxt = second_pend_r;
        wr_sel          = ptr_hit(reg_wr_addr);
        case (ptr_cmd)
            WRP_CMD_BOTH: begin
                first_pend_nxt  = ptr_imm;
                second_pend_nxt = ptr_imm + WRP_PAIR_STEP;
            end
            WRP_CMD_FIRST: begin
                first_pend_nxt = ptr_imm;
            end
            WRP_CMD_SECOND: begin
                second_pend_nxt = ptr_imm;
            end
            default: begin
                // ordinary load or clear into a pointer location
                if (reg_wr && wr_sel[0]) begin
                    first_pend_nxt = reg_wr_data;
                end else if (reg_wr && wr_sel[1]) begin
                    second_pend_nxt = reg_wr_data;
                end
            end
        endcase
        // commit at instruction boundary
        first_nxt  = instr_end ? first_pend_nxt : first_r;
        second_nxt = instr_end ? second_pend_nxt : second_r;
    end

    // register all pointer state
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            first_r       <= WRP_FIRST_PTR_RST;
            second_r      <= WRP_SECOND_PTR_RST;
            first_pend_r  <= WRP_FIRST_PTR_RST;
            second_pend_r <= WRP_SECOND_PTR_RST;
        end else if (clk_en) begin
            first_r       <= first_nxt;
            second_r      <= second_nxt;
            first_pend_r  <= first_pend_nxt;
            second_pend_r <= second_pend_nxt;
        end
    end

    // read back as stored, low bits included
    always_comb begin
        rd_sel      = ptr_hit(reg_rd_addr);
        reg_rd_hit  = 1'b0;
        reg_rd_data = 8'h00;
        if (rd_sel[0]) begin
            reg_rd_hit  = 1'b1;
            reg_rd_data = first_pend_r;
        end else if (rd_sel[1]) begin
            reg_rd_hit  = 1'b1;
            reg_rd_data = second_pend_r;
        end
    end

    // escape nibble turns an 8-bit operand into a working one
    always_comb begin
        is_work  = op_is_work || (op_addr[7:4] == WRP_WORK_NIBBLE);
        work_nib = op_addr[3:0];
    end

    wrp_addr_expand u_expand (
        .first_ptr  (first_r),
        .second_ptr (second_r),
        .operand    (work_nib),
        .full_addr  (work_addr)
    );

    // final address and set 2 guard
    always_comb begin
        // working addresses in C0-FF are set 1 whatever the page: the
        // pointer cannot reach set 2, so the common block stays shared
        if (is_work) begin
            eff_addr       = work_addr;
            eff_working    = 1'b1;
            eff_set2_block = 1'b0;
        end else begin
            eff_addr       = op_addr;
            eff_working    = 1'b0;
            // direct C0-FF goes to set 1 only; a set 2 target is refused
            eff_set2_block = (op_addr[7:6] == WRP_SET2_TOP) && !op_set1;
        end
        // pair: even address is the high byte, next odd the low byte
        eff_addr_lo = op_pair ? {eff_addr[7:1], 1'b1} : eff_addr;
        if (op_pair) begin
            eff_addr = {eff_addr[7:1], 1'b0};
        end
    end

    assign first_slice_pointer  = first_r;
    assign second_slice_pointer = second_r;

    // working operand address tracks committed pointer
    a_work_addr_form: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (op_is_work && !op_addr[3]) |-> eff_addr[7:3] == first_r[7:3] || op_pair)
        else $error("working address not from first pointer");
    // rst_b sits in the antecedents: a mid-run reset moves the pointers
    // with no instruction, and the edge that applies it must not count
    a_ptr_commit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rst_b && clk_en && !instr_end) |=> $stable(first_r) && $stable(second_r))
        else $error("pointer changed mid instruction");
    a_pair_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rst_b && clk_en && instr_end && ptr_cmd == WRP_CMD_BOTH)
        |=> second_r == ($past(ptr_imm) + WRP_PAIR_STEP) && first_r == $past(ptr_imm))
        else $error("combined set wrong");
    // a second-only set keeps the first pointer's pending copy
    a_single_keep: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rst_b && clk_en && ptr_cmd == WRP_CMD_SECOND)
        |=> first_pend_r == $past(first_pend_r))
        else $error("second set altered first pointer");
    a_nibble_escape: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (op_addr[7:4] == WRP_WORK_NIBBLE) |-> eff_working)
        else $error("escape nibble not working");
    a_no_set2: assert property (@(posedge clk_sys) disable iff (!rst_b)
        eff_working |-> !eff_set2_block)
        else $error("working access blocked as set 2");
    a_pair_order: assert property (@(posedge clk_sys) disable iff (!rst_b)
        op_pair |-> (!eff_addr[0] && eff_addr_lo == eff_addr + 8'h01))
        else $error("pair order wrong");
    a_reset_vals: assert property (@(posedge clk_sys)
        !rst_b |=> first_r == WRP_FIRST_PTR_RST && second_r == WRP_SECOND_PTR_RST)
        else $error("reset pointer values wrong");
    // bit 3 set operands take their slice from the second pointer
    a_work_second: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (op_is_work && op_addr[3]) |-> eff_addr[7:3] == second_r[7:3])
        else $error("working address not from second pointer");
    a_slot_pick: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (eff_working && !op_pair) |-> eff_addr[2:0] == op_addr[2:0])
        else $error("working slot bits not from operand");
    // first-only set must leave the second pending copy alone
    a_first_keep: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rst_b && clk_en && ptr_cmd == WRP_CMD_FIRST)
        |=> second_pend_r == $past(second_pend_r))
        else $error("first set altered second pointer");
    // a low enable holds live and pending pointers alike
    a_clk_freeze: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rst_b && !clk_en) |=> $stable(first_r) && $stable(second_r)
            && $stable(first_pend_r) && $stable(second_pend_r))
        else $error("pointer moved while frozen");
    // read port and direct path
    a_read_back: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (reg_rd_addr == WRP_SECOND_PTR_ADDR) |-> reg_rd_hit && reg_rd_data == second_pend_r)
        else $error("second pointer read back wrong");
    a_direct_pass: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!eff_working && !op_pair) |-> eff_addr == op_addr)
        else $error("direct address altered");
endmodule
`default_nettype wire

// file: wrp_dec_model.sv
// decoder model issuing pointer instructions and register writes
`timescale 1ns/1ps
`default_nettype none
module wrp_dec_model
    import wrp_pkg::*;
(
    input  wire logic  clk_sys,     // cpu clock
    output logic       clk_en,      // core enable, low only in a frozen cycle
    output logic       instr_end,   // last cycle of instruction
    output wrp_cmd_type ptr_cmd,    // pointer instruction kind
    output logic [7:0] ptr_imm,     // pointer immediate
    output logic       reg_wr,      // load or clear strobe
    output logic [7:0] reg_wr_addr, // written address
    output logic [7:0] reg_wr_data  // written data
);
    // quiet bus between instructions, so a stale write never repeats
    task automatic idle();
        clk_en      <= 1'b1;
        instr_end   <= 1'b0;
        ptr_cmd     <= WRP_CMD_NONE;
        ptr_imm     <= 8'h00;
        reg_wr      <= 1'b0;
        reg_wr_addr <= 8'h00;
        reg_wr_data <= 8'h00;
    endtask

    initial idle();

    // one instruction cycle, then idle; the write goes to whatever address the caller passes
    task automatic issue(input wrp_cmd_type c, input logic [7:0] i, input logic w,
                         input logic [7:0] a, input logic [7:0] d, input logic f);
        @(posedge clk_sys);
        ptr_cmd     <= c;
        ptr_imm     <= i;
        reg_wr      <= w;
        reg_wr_addr <= a;
        reg_wr_data <= d;
        instr_end   <= f;
        @(posedge clk_sys);
        idle();
    endtask

    // one commit cycle with the core frozen: nothing may move
    task automatic frozen(input wrp_cmd_type c, input logic [7:0] i);
        @(posedge clk_sys);
        clk_en    <= 1'b0;
        ptr_cmd   <= c;
        ptr_imm   <= i;
        instr_end <= 1'b1;
        @(posedge clk_sys);
        idle();
    endtask
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the working-register pointer core
`timescale 1ns/1ps
`default_nettype none
module tb
    import wrp_pkg::*;
;
    logic        clk_sys = 1'b0, rst_b = 1'b0;        // clock, reset
    logic        op_is_work = 1'b0, op_pair = 1'b0, op_set1 = 1'b0; // operand kind
    logic [7:0]  op_addr = 8'h00, reg_rd_addr = 8'h00; // operand, read address
    logic        clk_en, instr_end, reg_wr, reg_rd_hit, eff_working, eff_set2_block;
    wrp_cmd_type ptr_cmd;                             // from decoder model
    logic [7:0]  ptr_imm, reg_wr_addr, reg_wr_data, reg_rd_data, eff_addr, eff_addr_lo;
    logic [7:0]  first_slice_pointer, second_slice_pointer; // committed pointers
    int          fails = 0, samples_checked = 0;       // tallies

    always #20 clk_sys = ~clk_sys; // 25 MHz

    wrp_dec_model dec (.clk_sys, .clk_en, .instr_end, .ptr_cmd, .ptr_imm, .reg_wr,
                       .reg_wr_addr, .reg_wr_data);
    wrp_core dut (.clk_sys, .rst_b, .clk_en, .instr_end, .ptr_cmd, .ptr_imm, .reg_wr,
                  .reg_wr_addr, .reg_wr_data, .reg_rd_addr, .reg_rd_data, .reg_rd_hit,
                  .op_is_work, .op_addr, .op_pair, .op_set1, .eff_addr, .eff_addr_lo,
                  .eff_working, .eff_set2_block, .first_slice_pointer, .second_slice_pointer);

    // byte compare, case equality so unknowns fail
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // pointer outputs settle one edge after commit
    task automatic ptrs(input logic [7:0] e0, input logic [7:0] e1);
        @(negedge clk_sys);
        chk("first_ptr", e0, first_slice_pointer);
        chk("second_ptr", e1, second_slice_pointer);
    endtask

    // combinational read port
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        @(posedge clk_sys);
        reg_rd_addr <= a;
        @(negedge clk_sys);
        chk("rd_data", e, reg_rd_data);
        chk("rd_hit", {7'h00, h}, {7'h00, reg_rd_hit});
    endtask

    // combinational operand resolution
    task automatic op(input logic w, input logic [7:0] a, input logic p, input logic s,
                      input logic [7:0] e, input logic [7:0] lo, input logic ew,
                      input logic eb);
        @(posedge clk_sys);
        op_is_work <= w;
        op_addr    <= a;
        op_pair    <= p;
        op_set1    <= s;
        @(negedge clk_sys);
        chk("eff_addr", e, eff_addr);
        chk("eff_addr_lo", lo, eff_addr_lo);
        chk("eff_working", {7'h00, ew}, {7'h00, eff_working});
        chk("set2_block", {7'h00, eb}, {7'h00, eff_set2_block});
    endtask

    task automatic t_reset();
        ptrs(8'hC0, 8'hC8);
        rd(8'hD6, 8'hC0, 1'b1);
        rd(8'hD7, 8'hC8, 1'b1);
        op(1'b1, 8'h0F, 1'b0, 1'b0, 8'hCF, 8'hCF, 1'b1, 1'b0);
    endtask

    task automatic t_both();
        dec.issue(WRP_CMD_BOTH, 8'h70, 1'b0, 8'h00, 8'h00, 1'b1);
        ptrs(8'h70, 8'h78);
        op(1'b1, 8'h06, 1'b0, 1'b0, 8'h76, 8'h76, 1'b1, 1'b0);
        op(1'b1, 8'h0E, 1'b0, 1'b0, 8'h7E, 8'h7E, 1'b1, 1'b0);
        op(1'b0, 8'hC5, 1'b0, 1'b0, 8'h75, 8'h75, 1'b1, 1'b0);
        op(1'b1, 8'h03, 1'b1, 1'b0, 8'h72, 8'h73, 1'b1, 1'b0);
    endtask

    // reversed slices are legal for software
    task automatic t_single();
        dec.issue(WRP_CMD_SECOND, 8'h48, 1'b0, 8'h00, 8'h00, 1'b1);
        ptrs(8'h70, 8'h48);
        dec.issue(WRP_CMD_FIRST, 8'hA5, 1'b0, 8'h00, 8'h00, 1'b1);
        ptrs(8'hA5, 8'h48);
        op(1'b1, 8'h02, 1'b0, 1'b0, 8'hA2, 8'hA2, 1'b1, 1'b0);
        rd(8'hD6, 8'hA5, 1'b1);
    endtask

    task automatic t_regwr();
        dec.issue(WRP_CMD_NONE, 8'h00, 1'b1, 8'hD6, 8'h00, 1'b0);
        ptrs(8'hA5, 8'h48);
        dec.issue(WRP_CMD_NONE, 8'h00, 1'b1, 8'hD7, 8'hF8, 1'b1);
        ptrs(8'h00, 8'hF8);
        dec.issue(WRP_CMD_FIRST, 8'h10, 1'b1, 8'hD7, 8'h11, 1'b1);
        ptrs(8'h10, 8'hF8);
        rd(8'hD5, 8'h00, 1'b0);
    endtask

    // a commit with the enable low must change nothing
    task automatic t_freeze();
        dec.frozen(WRP_CMD_BOTH, 8'h30);
        ptrs(8'h10, 8'hF8);
        rd(8'hD6, 8'h10, 1'b1);
        rd(8'hD7, 8'hF8, 1'b1);
    endtask

    // second reset in mid-run returns live and pending pointers to C0 and C8
    task automatic t_rerst();
        @(posedge clk_sys);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        rst_b <= 1'b1;
        ptrs(8'hC0, 8'hC8);
        rd(8'hD7, 8'hC8, 1'b1);
    endtask

    task automatic t_direct();
        op(1'b0, 8'h45, 1'b0, 1'b0, 8'h45, 8'h45, 1'b0, 1'b0);
        op(1'b0, 8'h44, 1'b1, 1'b0, 8'h44, 8'h45, 1'b0, 1'b0);
        op(1'b0, 8'hD5, 1'b0, 1'b1, 8'hD5, 8'hD5, 1'b0, 1'b0);
        op(1'b0, 8'hD5, 1'b0, 1'b0, 8'hD5, 8'hD5, 1'b0, 1'b1);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_both();
        t_single();
        t_regwr();
        t_freeze();
        t_rerst();
        t_direct();
        complete_run();
    end
endmodule
`default_nettype wire
